// File: hw/asprt_pkg.sv
// Constants, register map and state types of the asynchronous serial transceiver.
// Assumes a 32-bit classic Wishbone master and a 100 MHz system clock.
// Contract
// R01: Even parity transmit: bit equals data ones parity.
// R02: Even parity receive: odd total flags error.
// R03: Odd parity transmit: bit inverts data ones parity.
// R04: Odd parity receive: even total flags error.
// R05: Zero parity sends 0, never checked.
// R06: No parity: bit omitted, never checked.
// R07: Transmit only when enabled; data write starts.
// R08: Start, parity, stop bits added by hardware.
// R09: Shift register empty raises transmit done request.
// R10: Software leaves mode alone during transmission.
// R11: Receive sampling only while receive enabled.
// R12: Falling line, half-bit resample confirms start.
// R13: Frame ends after data, parity, one stop.
// R14: Completed frame goes to buffer, done request.
// R15: Errored frame buffered; done only if mode set.
// R16: Receive disable aborts; buffer, status, requests untouched.
// R17: Error request comes before completion request.
// R18: Status codes: parity 04, framing 02, overrun 01.
// R19: Overrun when frame ends before buffer read.
// R20: Status cleared by buffer read or next frame.
// R21: Software reads status before receive buffer.
// R22: Software always reads buffer, even after errors.
// R23: Overrun frame is discarded, buffer kept.
// R24: Bit time is twice divider k input clocks.
// R25: Seven-bit characters: bit 7 ignored, reads 0.
// R26: Transmit line idles high between frames.
package asprt_pkg;

  localparam int ADR_W = 5;
  localparam int DAT_W = 32;

  // Word indices on the bus (byte address is four times the index).
  localparam logic [2:0] IDX_MODE = 3'h0;
  localparam logic [2:0] IDX_STATUS = 3'h1;
  localparam logic [2:0] IDX_TXDATA = 3'h2;
  localparam logic [2:0] IDX_RXBUF = 3'h3;
  localparam logic [2:0] IDX_BAUD = 3'h4;
  localparam logic [2:0] IDX_IRQFLAG = 3'h5;

  // serial_mode_reg fields.
  localparam int MODE_TXE_BIT = 7;
  localparam int MODE_RXE_BIT = 5;
  localparam int MODE_PAR_LSB = 3;
  localparam int MODE_CL_BIT = 2;
  localparam int MODE_SL_BIT = 1;
  localparam int MODE_ERR_IRQ_MODE_BIT_BIT = 0;
  localparam logic [7:0] MODE_RST = 8'h00;

  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;

  // Baud register: prescaler select in 7:6, baud_divider_field in 4:0.
  localparam int BAUD_K_MSB = 4;
  localparam int BAUD_TPS_LSB = 6;
  localparam logic [7:0] BAUD_RST = 8'h1F;

  // rx_status_reg flags.
  localparam int ST_PE_BIT = 2;
  localparam int ST_FE_BIT = 1;
  localparam int ST_OVE_BIT = 0;

  // Sticky request flags, write one to clear.
  localparam int IF_TX_BIT = 0;
  localparam int IF_RX_BIT = 1;
  localparam int IF_ERR_BIT = 2;

  localparam logic [3:0] CHAR_LEN_8 = 4'h8;
  localparam logic [3:0] CHAR_LEN_7 = 4'h7;
  localparam logic [7:0] CHAR_MASK_7 = 8'h7F;

  typedef enum logic {TX_IDLE, TX_SHIFT} asprt_tx_st_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} asprt_rx_st_t;

  typedef struct packed {
    logic wb_ack;
    logic [DAT_W-1:0] wb_dat;
    logic [7:0] mode;
    logic [7:0] baud;
    logic [2:0] status;
    logic [7:0] rxbuf;
    logic rx_unread;
    logic [2:0] irq_flag;
    logic tx_done;
    logic rx_done;
    logic rx_err;
    logic rx_done_pend;
    logic [2:0] pre;
    asprt_tx_st_t tx_st;
    logic [11:0] tx_sh;
    logic [3:0] tx_left;
    logic [5:0] tx_cnt;
    logic txd;
    asprt_rx_st_t rx_st;
    logic [9:0] rx_sh;
    logic [3:0] rx_idx;
    logic [5:0] rx_cnt;
  } asprt_state_t;

endpackage

// File: hw/asprt_top.sv
// Asynchronous serial transceiver with parity, framing and overrun checks.
// Assumes a classic Wishbone master and a partner whose line is synchronous to clk_i.
//
// The Wishbone interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none

module asprt_top
  import asprt_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [DAT_W-1:0] wb_dat_i,
  output logic [DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Serial line.
  input wire logic serial_rx_pin_i,
  output logic serial_tx_pin_o,
  // Request pulses.
  output logic tx_done_irq_o,
  output logic rx_done_irq_o,
  output logic rx_error_irq_o
);

  asprt_state_t s_ff;
  asprt_state_t nxt_s;

  logic [4:0] k;
  logic [5:0] bit_last;
  logic [5:0] half_last;
  logic [1:0] tps;
  logic [2:0] pre_mask;
  logic tick;
  logic char8;
  logic [1:0] par;
  logic has_par;
  logic two_stop;
  logic [3:0] n_data;
  logic [3:0] rx_last;
  logic [2:0] idx;
  logic req;
  logic wr;
  logic rd;
  logic [7:0] tx_data;
  logic tx_ones;

  // Bit time is 2k prescaled ticks; start check lands after k ticks. [R24] [R12]
  assign k = s_ff.baud[BAUD_K_MSB:0];
  assign bit_last = {k, 1'b0} - 6'h01;
  assign half_last = {1'b0, k} - 6'h01;
  assign tps = s_ff.baud[BAUD_TPS_LSB+:2];
  assign pre_mask = 3'((4'h1 << tps) - 4'h1);
  assign tick = (s_ff.pre & pre_mask) == pre_mask;

  assign char8 = s_ff.mode[MODE_CL_BIT];
  assign par = s_ff.mode[MODE_PAR_LSB+:2];
  assign has_par = par != PAR_NONE;
  assign two_stop = s_ff.mode[MODE_SL_BIT];
  assign n_data = char8 ? CHAR_LEN_8 : CHAR_LEN_7;
  assign rx_last = n_data + {3'h0, has_par};

  assign idx = wb_adr_i[4:2];
  assign req = wb_cyc_i & wb_stb_i & ~s_ff.wb_ack;
  assign wr = req & wb_we_i & wb_sel_i[0];
  assign rd = req & ~wb_we_i;

  // In seven-bit mode bit 7 of the written byte never reaches the line. [R25]
  assign tx_data = char8 ? wb_dat_i[7:0] : (wb_dat_i[7:0] & CHAR_MASK_7);
  assign tx_ones = ^tx_data;

  always_comb begin
    logic [11:0] fr;
    logic [9:0] fsh;
    logic [7:0] rdata;
    logic pbit;
    logic pe;
    logic fe;
    logic ov;
    logic [3:0] pidx;
    fr = '1;
    fsh = '0;
    rdata = '0;
    pbit = 1'b0;
    pe = 1'b0;
    fe = 1'b0;
    ov = 1'b0;
    pidx = '0;
    nxt_s = s_ff;
    nxt_s.wb_ack = req;
    nxt_s.tx_done = 1'b0;
    nxt_s.rx_done = 1'b0;
    nxt_s.rx_err = 1'b0;
    nxt_s.pre = s_ff.pre + 3'h1;

    // Register reads; reading the buffer wipes the status flags. [R20]
    unique case (idx)
      IDX_MODE: rdata = s_ff.mode;
      IDX_STATUS: rdata = {5'h00, s_ff.status};
      IDX_RXBUF: rdata = s_ff.rxbuf;
      IDX_BAUD: rdata = s_ff.baud;
      IDX_IRQFLAG: rdata = {5'h00, s_ff.irq_flag};
      default: rdata = 8'h00;
    endcase
    if (rd) begin
      nxt_s.wb_dat = {24'h000000, rdata};
      if (idx == IDX_RXBUF) begin
        nxt_s.status = '0; // [R20]
        nxt_s.rx_unread = 1'b0;
      end
    end else if (req) begin
      nxt_s.wb_dat = '0;
    end

    if (wr) begin
      unique case (idx)
        IDX_MODE: nxt_s.mode = wb_dat_i[7:0];
        IDX_BAUD: nxt_s.baud = wb_dat_i[7:0];
        IDX_IRQFLAG: nxt_s.irq_flag = s_ff.irq_flag & ~wb_dat_i[2:0];
        default: ;
      endcase
    end

    // Transmitter.
    unique case (s_ff.tx_st)
      TX_IDLE: begin
        nxt_s.txd = 1'b1; // [R26]
        if (wr && idx == IDX_TXDATA && s_ff.mode[MODE_TXE_BIT]) begin // [R07]
          unique case (par)
            PAR_EVEN: pbit = tx_ones; // [R01]
            PAR_ODD: pbit = ~tx_ones; // [R03]
            default: pbit = 1'b0; // [R05]
          endcase
          // Ones above the data double as stop bits, so no-parity just skips a slot. [R08]
          fr[0] = 1'b0;
          fr[8:1] = char8 ? tx_data : {1'b1, tx_data[6:0]};
          pidx = n_data + 4'h1;
          if (has_par) begin
            fr[pidx] = pbit; // [R06]
          end
          nxt_s.txd = fr[0];
          nxt_s.tx_sh = {1'b1, fr[11:1]};
          nxt_s.tx_left = n_data + {3'h0, has_par} + {3'h0, two_stop} + 4'h1;
          nxt_s.tx_cnt = '0;
          nxt_s.tx_st = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        if (tick) begin
          if (s_ff.tx_cnt == bit_last) begin
            nxt_s.tx_cnt = '0;
            if (s_ff.tx_left == 4'h0) begin
              nxt_s.tx_st = TX_IDLE;
              nxt_s.tx_done = 1'b1; // [R09]
            end else begin
              nxt_s.txd = s_ff.tx_sh[0];
              nxt_s.tx_sh = {1'b1, s_ff.tx_sh[11:1]};
              nxt_s.tx_left = s_ff.tx_left - 4'h1;
            end
          end else begin
            nxt_s.tx_cnt = s_ff.tx_cnt + 6'h01;
          end
        end
      end
    endcase

    // Completion follows the error request by one cycle. [R17]
    if (s_ff.rx_done_pend) begin
      nxt_s.rx_done_pend = 1'b0;
      nxt_s.rx_done = 1'b1;
    end

    // Receiver.
    if (!s_ff.mode[MODE_RXE_BIT]) begin
      nxt_s.rx_st = RX_IDLE; // [R11] [R16]
    end else begin
      unique case (s_ff.rx_st)
        RX_IDLE: begin
          if (!serial_rx_pin_i) begin
            nxt_s.rx_st = RX_START; // [R12]
            nxt_s.rx_cnt = '0;
          end
        end
        RX_START: begin
          if (tick) begin
            if (s_ff.rx_cnt == half_last) begin
              nxt_s.rx_cnt = '0;
              nxt_s.rx_idx = '0;
              nxt_s.rx_st = serial_rx_pin_i ? RX_IDLE : RX_DATA; // [R12]
            end else begin
              nxt_s.rx_cnt = s_ff.rx_cnt + 6'h01;
            end
          end
        end
        RX_DATA: begin
          if (tick) begin
            if (s_ff.rx_cnt == bit_last) begin
              nxt_s.rx_cnt = '0;
              fsh = s_ff.rx_sh;
              fsh[s_ff.rx_idx] = serial_rx_pin_i;
              nxt_s.rx_sh = fsh;
              nxt_s.rx_idx = s_ff.rx_idx + 4'h1;
              // Only one stop bit is checked, even with two configured. [R13]
              if (s_ff.rx_idx == rx_last) begin
                nxt_s.rx_st = RX_IDLE;
                // Parity and stop are taken before bit 7 is masked, as in seven-bit frames the parity bit,
                // or the stop bit when there is no parity, sits in that slot.
                pbit = fsh[n_data];
                fe = ~fsh[rx_last];
                if (!char8) begin
                  fsh[7] = 1'b0; // [R25]
                end
                pe = (par == PAR_EVEN) ? (^fsh[7:0] ^ pbit) : 1'b0; // [R02] [R05] [R06]
                if (par == PAR_ODD) begin
                  pe = ~(^fsh[7:0] ^ pbit); // [R04]
                end
                // A read in this same cycle has already cleared the unread mark. [R19]
                ov = nxt_s.rx_unread;
                nxt_s.status = '0; // [R20]
                nxt_s.status[ST_PE_BIT] = pe; // [R18]
                nxt_s.status[ST_FE_BIT] = fe;
                nxt_s.status[ST_OVE_BIT] = ov;
                if (!ov) begin
                  nxt_s.rxbuf = fsh[7:0]; // [R14] [R15] [R23]
                  nxt_s.rx_unread = 1'b1;
                end
                if (pe || fe || ov) begin
                  nxt_s.rx_err = 1'b1; // [R17]
                  nxt_s.rx_done_pend = s_ff.mode[MODE_ERR_IRQ_MODE_BIT_BIT]; // [R15]
                end else begin
                  nxt_s.rx_done = 1'b1; // [R14]
                end
              end
            end else begin
              nxt_s.rx_cnt = s_ff.rx_cnt + 6'h01;
            end
          end
        end
        default: nxt_s.rx_st = RX_IDLE;
      endcase
    end

    // Sticky flags: a set in the clearing cycle wins.
    nxt_s.irq_flag[IF_TX_BIT] = nxt_s.irq_flag[IF_TX_BIT] | nxt_s.tx_done; // [R09]
    nxt_s.irq_flag[IF_RX_BIT] = nxt_s.irq_flag[IF_RX_BIT] | nxt_s.rx_done;
    nxt_s.irq_flag[IF_ERR_BIT] = nxt_s.irq_flag[IF_ERR_BIT] | nxt_s.rx_err;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_ff <= '0;
      s_ff.mode <= MODE_RST;
      s_ff.baud <= BAUD_RST;
      s_ff.txd <= 1'b1;
      s_ff.tx_st <= TX_IDLE;
      s_ff.rx_st <= RX_IDLE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign wb_ack_o = s_ff.wb_ack;
  assign wb_dat_o = s_ff.wb_dat;
  assign serial_tx_pin_o = s_ff.txd;
  assign tx_done_irq_o = s_ff.tx_done;
  assign rx_done_irq_o = s_ff.rx_done;
  assign rx_error_irq_o = s_ff.rx_err;

endmodule

`default_nettype wire

// File: testbench/asprt_asserts.sv
// Checker of bus handshake, line framing and request pulses.
// Assumes k=8 and no prescale, so one bit lasts 16 clocks.
`timescale 1ns/1ps
`default_nettype none
module asprt_asserts
  import asprt_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [DAT_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Line and requests.
  input wire logic serial_tx_pin_o,
  input wire logic tx_done_irq_o,
  input wire logic rx_done_irq_o,
  input wire logic rx_error_irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  a_status_code: assert property (wb_ack_o && !wb_we_i &&
    wb_adr_i[4:2] == IDX_STATUS |-> wb_dat_o[31:3] == 29'h0) else $error("status bits");
  // Reset must not be masked here, the idle level is what is checked.
  a_tx_idle_reset: assert property (disable iff (1'b0) rst_i |=> serial_tx_pin_o)
    else $error("tx not idle");
  // A falling line stays low for 8 clocks and is low again 15 clocks after the edge.
  a_low_bit_len: assert property ($fell(serial_tx_pin_o) |->
    (!serial_tx_pin_o) [*8] ##8 !serial_tx_pin_o) else $error("bit short");
  a_done_after_stop: assert property (tx_done_irq_o |->
    serial_tx_pin_o && $past(serial_tx_pin_o, 8) ##1 !tx_done_irq_o) else $error("tx done");
  a_err_first: assert property (rx_error_irq_o |-> !rx_done_irq_o ##1 !rx_error_irq_o)
    else $error("error order");
  a_done_single: assert property (rx_done_irq_o |=> !rx_done_irq_o)
    else $error("rx done held");
endmodule
bind asprt_top asprt_asserts u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .serial_tx_pin_o(serial_tx_pin_o), .tx_done_irq_o(tx_done_irq_o),
  .rx_done_irq_o(rx_done_irq_o), .rx_error_irq_o(rx_error_irq_o));
`default_nettype wire

// File: testbench/asprt_partner.sv
// Remote serial partner: sends frames to the receiver, samples the transmitter.
// Assumes a bit time of 16 clocks, as the bench programs it.
`timescale 1ns/1ps
`default_nettype none
module asprt_partner
  import asprt_pkg::*;
(
  input wire logic clk_i,
  input wire logic tx_line_i,
  output logic rx_line_o
);
  initial rx_line_o = 1'b1;
  // A bad stop bit is cut short so the receiver cannot see a new start in it.
  task automatic send(input logic [7:0] d, input logic [1:0] pm, input logic bp, bs);
    logic [10:0] f;
    int n;
    begin
      n = (pm == PAR_NONE) ? 10 : 11;
      f = {~bs, ((pm == PAR_ZERO) ? 1'b0 : (^d ^ (pm == PAR_ODD))) ^ bp, d, 1'b0};
      if (pm == PAR_NONE) f[9] = ~bs;
      for (int i = 0; i < n; i++) begin
        rx_line_o <= f[i];
        repeat ((bs && i == n - 1) ? 10 : 16) @(posedge clk_i);
      end
      rx_line_o <= 1'b1;
    end
  endtask
  task automatic capture(output logic [10:0] b);
    begin
      @(negedge clk_i);
      while (tx_line_i) @(negedge clk_i);
      repeat (8) @(negedge clk_i);
      for (int i = 0; i < 11; i++) begin
        b[i] = tx_line_i;
        repeat (16) @(negedge clk_i);
      end
    end
  endtask
endmodule
`default_nettype wire

// File: testbench/asprt_top_test.sv
// Self-checking bench: registers, transmit framing, receive errors.
// Assumes the partner model and the bound checker are compiled with the design.
`timescale 1ns/1ps
`default_nettype none
module asprt_top_test
  import asprt_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [ADR_W-1:0] adr = '0;
  logic [DAT_W-1:0] wdat = '0, rdat, dat_o;
  logic ack, rx_line, tx_line, tx_done, rx_done, rx_err;
  logic [10:0] fr;
  int fail_count = 0, compares = 0, cycles = 0;
  int n_err = 0, n_done = 0, n_tx = 0, n_low = 0;
  always #5 clk_i = ~clk_i;
  asprt_top DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .serial_rx_pin_i(rx_line), .serial_tx_pin_o(tx_line), .tx_done_irq_o(tx_done),
    .rx_done_irq_o(rx_done), .rx_error_irq_o(rx_err));
  asprt_partner partner (.clk_i(clk_i), .tx_line_i(tx_line), .rx_line_o(rx_line));
  // Pulses are counted at the falling edge, clear of the register updates.
  always @(negedge clk_i) begin
    cycles++;
    n_err += rx_err;
    n_done += rx_done;
    n_tx += tx_done;
    n_low += !tx_line;
    if (cycles == 20000) begin
      fail_count++;
      results();
    end
  end
  task automatic results();
    begin
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  task automatic chk(input string nm, input logic [31:0] got, exp);
    begin
      compares++;
      if (got !== exp) begin
        fail_count++;
        $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task automatic bus(input logic w, input logic [2:0] idx, input logic [7:0] d);
    begin
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      wdat <= {24'h0, d};
      do @(negedge clk_i); while (ack !== 1'b1);
      @(posedge clk_i);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  task automatic tx_case(input logic [1:0] pm, input logic [7:0] d);
    logic p;
    begin
      p = (pm == PAR_ZERO) ? 1'b0 : (^d ^ (pm == PAR_ODD));
      bus(1'b1, IDX_MODE, 8'h84 | {3'h0, pm, 3'h0});
      n_tx = 0;
      fork partner.capture(fr); join_none
      bus(1'b1, IDX_TXDATA, d);
      repeat (200) @(posedge clk_i);
      chk("tx frame", {21'h0, fr}, (pm == PAR_NONE) ? {21'h0, 2'b11, d, 1'b0} :
        {21'h0, 1'b1, p, d, 1'b0});
      chk("tx done", n_tx, 1);
      $display("tx test %0d done", pm);
    end
  endtask
  task automatic rx_case(input logic [7:0] d, input logic [1:0] pm, input logic bp, bs, im,
    rd, input logic [7:0] st, bx, input int ne, nd);
    begin
      bus(1'b1, IDX_MODE, 8'h24 | {3'h0, pm, 3'h0} | {7'h0, im});
      n_err = 0;
      n_done = 0;
      partner.send(d, pm, bp, bs);
      repeat (24) @(posedge clk_i);
      bus(1'b0, IDX_STATUS, 8'h00);
      chk("rx status", rdat, {24'h0, st});
      chk("rx error pulses", n_err, ne);
      chk("rx done pulses", n_done, nd);
      if (rd) begin
        bus(1'b0, IDX_RXBUF, 8'h00);
        chk("rx buffer", rdat, {24'h0, bx});
        bus(1'b0, IDX_STATUS, 8'h00);
        chk("status after read", rdat, 32'h0);
      end
      $display("rx test %h done", d);
    end
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(1'b0, IDX_MODE, 8'h00);
    chk("mode reset", rdat, 32'h0);
    bus(1'b0, IDX_BAUD, 8'h00);
    chk("baud reset", rdat, 32'h1F);
    bus(1'b0, 3'h7, 8'h00);
    chk("unmapped read", rdat, 32'h0);
    bus(1'b1, IDX_BAUD, 8'h08);
    for (int m = 0; m < 4; m++) tx_case(m[1:0], 8'hB4 ^ m[7:0]);
    bus(1'b1, IDX_MODE, 8'h92);
    n_tx = 0;
    fork partner.capture(fr); join_none
    bus(1'b1, IDX_TXDATA, 8'hB5);
    repeat (200) @(posedge clk_i);
    chk("tx seven bit frame", {21'h0, fr}, 32'h76A);
    chk("tx seven bit done", n_tx, 1);
    $display("tx seven bit test done");
    bus(1'b0, IDX_IRQFLAG, 8'h00);
    chk("tx flag", {31'h0, rdat[IF_TX_BIT]}, 32'h1);
    bus(1'b1, IDX_MODE, 8'h04);
    n_low = 0;
    n_tx = 0;
    bus(1'b1, IDX_TXDATA, 8'h00);
    repeat (40) @(posedge clk_i);
    chk("tx disabled", n_low + n_tx, 0);
    rx_case(8'h5A, PAR_EVEN, 0, 0, 0, 1, 8'h00, 8'h5A, 0, 1);
    rx_case(8'h3C, PAR_ODD, 1, 0, 0, 1, 8'h04, 8'h3C, 1, 0);
    rx_case(8'h81, PAR_ZERO, 1, 0, 0, 1, 8'h00, 8'h81, 0, 1);
    rx_case(8'hC3, PAR_NONE, 0, 1, 1, 1, 8'h02, 8'hC3, 1, 1);
    rx_case(8'h11, PAR_EVEN, 1, 0, 1, 0, 8'h04, 8'h00, 1, 1);
    rx_case(8'h22, PAR_EVEN, 0, 0, 1, 1, 8'h01, 8'h11, 1, 1);
    n_err = 0;
    n_done = 0;
    bus(1'b1, IDX_MODE, 8'h3C);
    fork
      partner.send(8'h66, PAR_EVEN, 1'b0, 1'b0);
      begin
        repeat (60) @(posedge clk_i);
        bus(1'b1, IDX_MODE, 8'h04);
      end
    join
    repeat (24) @(posedge clk_i);
    bus(1'b0, IDX_STATUS, 8'h00);
    chk("abort status", rdat, 32'h0);
    chk("abort pulses", n_err + n_done, 0);
    bus(1'b0, IDX_RXBUF, 8'h00);
    chk("abort buffer", rdat, 32'h11);
    $display("abort test done");
    bus(1'b0, IDX_IRQFLAG, 8'h00);
    chk("request flags", rdat, 32'h7);
    bus(1'b1, IDX_IRQFLAG, 8'h07);
    bus(1'b0, IDX_IRQFLAG, 8'h00);
    chk("flags cleared", rdat, 32'h0);
    $display("flag test done");
    results();
  end
endmodule
`default_nettype wire
